// ==== verilog/pdhp_top.sv ====
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// (R1) Codes 1-4 select downstream pseudowire types
// (R2) Upstream codes decoded, never accepted downstream
// (R3) Codes 13,14,21,24,19 are downstream flows
// (R4) Headend carries subtype in setup messages
// (R5) Node reports session subtype in reply
// (R6) Latency DSCP attribute: type 18, length 8
// (R7) Return-path DSCP attribute: type 19, length 8
// (R8) Multicast port attribute: type 20, 16-bit port
// (R9) Transport bit must be zero for data
// (R10) Eleven reserved header bits are ignored
// (R11) Sender drives version field as 3
// (R12) Sixteen-bit reserved field is ignored
// (R13) Session identifier selects configured session
// (R14) No cookie follows session identifier
// (R15) UDP framing adds parsed data header word
// (R16) Headend prepends sublayer matching session type
// (R17) Accept packets matching negotiated session type
// (R18) Wrong type flags session for teardown
// (R19) Nonconforming sublayer headers are silently dropped
// (R20) MPEG sessions cut into 188-byte segments
// (R21) Streaming segments passed as frames or fragments
// (R22) Sequence gaps counted as lost packets
// (R23) Reserved or out-of-range subtypes rejected
// (R24) Unknown session packets discarded and counted
module pdhp_top #(
  parameter int SESSIONS = 8,
  parameter logic [15:0] SUBTYPE_AVP_TYPE = 16'h0001,
  parameter logic [15:0] AVP_VENDOR = 16'h0000 // Arbitrary value
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic IN_VALID,
  input wire logic [7:0] IN_DATA,
  input wire logic IN_SOP,
  input wire logic IN_EOP,
  output logic OUT_VALID,
  output logic [7:0] OUT_DATA,
  output logic OUT_SOS,
  output logic OUT_EOS,
  output logic OUT_EOP,
  output logic OUT_ERR,
  output logic OUT_MPEG,
  output logic [$clog2(SESSIONS)-1:0] OUT_SESS,
  output logic TEARDOWN_REQ
);
  localparam int IW = $clog2(SESSIONS);

  ////////////////////////////////////////////////////////////////////////////
  // Subtype decode: {valid, downstream, mpeg}
  function automatic logic [2:0] decode_sub(input logic [4:0] s);
    unique case (s)
      pdhp_pkg::SUB_MTS, pdhp_pkg::SUB_MCH, pdhp_pkg::SUB_MTS_FWD2: decode_sub = 3'h7; // R1 R3
      pdhp_pkg::SUB_PKT_LEGACY, pdhp_pkg::SUB_PKT_MC: decode_sub = 3'h6; // R1
      pdhp_pkg::SUB_MAP_SCQ, pdhp_pkg::SUB_MAP_OFDMA, pdhp_pkg::SUB_NDF, pdhp_pkg::SUB_ZBL: decode_sub = 3'h6; // R3
      pdhp_pkg::SUB_MTS_RET1, pdhp_pkg::SUB_MTS_RET2: decode_sub = 3'h5; // R2
      pdhp_pkg::SUB_US_SCQAM, pdhp_pkg::SUB_US_OFDMA, pdhp_pkg::SUB_BWREQ_SCQ, pdhp_pkg::SUB_BWREQ_OFDMA,
      pdhp_pkg::SUB_PROBE, pdhp_pkg::SUB_RNG_SCQ, pdhp_pkg::SUB_RNG_OFDMA, pdhp_pkg::SUB_SPECMAN,
      pdhp_pkg::SUB_PNM, pdhp_pkg::SUB_NDR, pdhp_pkg::SUB_EC: decode_sub = 3'h4; // R2
      default: decode_sub = 3'h0; // R23
    endcase
  endfunction : decode_sub

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic ctrl_en_reg;
  logic ctrl_udp_reg;
  logic cfg_rej_reg;
  logic [IW-1:0] sel_reg;
  logic [31:0] sess_id_mem [SESSIONS];
  logic sess_val_mem [SESSIONS];
  logic [4:0] sess_sub_mem [SESSIONS];
  logic [15:0] last_seq_mem [SESSIONS];
  logic seq_seen_mem [SESSIONS];
  logic [SESSIONS-1:0] tear_reg;
  logic [31:0] cnt_nosess_reg;
  logic [31:0] cnt_badhdr_reg;
  logic [31:0] cnt_seqloss_reg;
  logic [1:0] avp_kind_reg;
  logic [15:0] avp_val_reg;
  pdhp_pkg::pdhp_state_e st_reg;
  pdhp_pkg::pdhp_state_e st_next;
  pdhp_pkg::pdhp_state_e st_cur;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [1:0] cnt_cur;
  logic [23:0] sid_reg;
  logic [IW-1:0] idx_reg;
  logic mpeg_reg;
  logic seqv_reg;
  logic [7:0] seq_hi_reg;
  logic [7:0] seg_reg;
  logic [31:0] rd_next;

  logic byte_in;
  logic [SESSIONS-1:0] hit;
  logic [IW-1:0] hit_idx;
  logic hit_any;
  logic [2:0] hit_cls;
  logic ev_nosess;
  logic ev_badhdr;
  logic ev_seqloss;
  logic ev_tear;
  logic [IW-1:0] tear_idx;
  logic seq_upd;
  logic emit;
  logic seg_err;
  logic [15:0] seq_now;
  logic wr_cfg;
  logic [2:0] wr_cls;
  logic [31:0] avp_w0;
  logic [31:0] avp_w1;

  assign byte_in = CE && IN_VALID;
  assign seq_now = {seq_hi_reg, IN_DATA};
  assign wr_cfg = CE && WR && ADDR == pdhp_pkg::ADDR_SESS_CFG;
  assign wr_cls = decode_sub(WDATA[pdhp_pkg::CFG_SUB_LSB +: 5]);

  ////////////////////////////////////////////////////////////////////////////
  // Session lookup
  genvar gi;
  generate
    for (gi = 0; gi < SESSIONS; gi++) begin : g_match
      assign hit[gi] = sess_val_mem[gi] && sess_id_mem[gi] == {sid_reg, IN_DATA}; // R13 R14
    end
  endgenerate

  always_comb begin
    hit_idx = '0;
    hit_any = 1'b0;
    for (int i = SESSIONS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_idx = IW'(i);
        hit_any = 1'b1;
      end
    end
    hit_cls = decode_sub(sess_sub_mem[hit_idx]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet parser
  always_comb begin
    st_cur = st_reg;
    cnt_cur = cnt_reg;
    if (IN_SOP) begin
      st_cur = !ctrl_en_reg ? pdhp_pkg::ST_DROP : ctrl_udp_reg ? pdhp_pkg::ST_HDR : pdhp_pkg::ST_SID; // R15
      cnt_cur = 2'h0;
    end
    st_next = st_reg;
    ev_nosess = 1'b0;
    ev_badhdr = 1'b0;
    ev_seqloss = 1'b0;
    ev_tear = 1'b0;
    tear_idx = idx_reg;
    seq_upd = 1'b0;
    emit = 1'b0;
    seg_err = 1'b0;
    if (byte_in) begin
      st_next = st_cur;
      unique case (st_cur)
        pdhp_pkg::ST_IDLE: st_next = pdhp_pkg::ST_IDLE;
        pdhp_pkg::ST_HDR: begin
          // Reserved and version bits are not checked
          if (cnt_cur == 2'h0 && IN_DATA[pdhp_pkg::HDR_T_BIT]) begin // R9 R10 R12
            ev_badhdr = 1'b1;
            st_next = pdhp_pkg::ST_DROP;
          end else if (cnt_cur == pdhp_pkg::HDR_LAST) begin
            st_next = pdhp_pkg::ST_SID;
          end
        end
        pdhp_pkg::ST_SID: begin
          if (cnt_cur == pdhp_pkg::HDR_LAST) begin
            tear_idx = hit_idx;
            if (!hit_any) begin
              ev_nosess = 1'b1; // R24
              st_next = pdhp_pkg::ST_DROP;
            end else if (!hit_cls[1]) begin
              ev_tear = 1'b1; // R18
              st_next = pdhp_pkg::ST_DROP;
            end else begin
              st_next = pdhp_pkg::ST_SUB; // R17
            end
          end
        end
        pdhp_pkg::ST_SUB: begin
          if (cnt_cur == 2'h0 && (IN_DATA[pdhp_pkg::SUB_V_BIT] || IN_DATA[pdhp_pkg::SUB_H_MSB])) begin
            ev_badhdr = 1'b1; // R19
            st_next = pdhp_pkg::ST_DROP;
          end else if (cnt_cur == 2'h0 && IN_DATA[pdhp_pkg::SUB_H_MSB:pdhp_pkg::SUB_H_LSB] == pdhp_pkg::H_LATENCY) begin
            st_next = pdhp_pkg::ST_DROP;
          end else if (cnt_cur == pdhp_pkg::HDR_LAST) begin
            seq_upd = seqv_reg;
            ev_seqloss = seqv_reg && seq_seen_mem[idx_reg] && seq_now != last_seq_mem[idx_reg] + 16'h0001; // R22
            st_next = pdhp_pkg::ST_PAY;
          end
        end
        pdhp_pkg::ST_PAY: begin
          emit = 1'b1;
          if (IN_EOP && mpeg_reg && seg_reg != pdhp_pkg::MPEG_SEG_LAST) begin
            seg_err = 1'b1; // R20
            ev_tear = 1'b1; // R18
          end
        end
        pdhp_pkg::ST_DROP: st_next = pdhp_pkg::ST_DROP;
      endcase
      if (IN_EOP) begin
        if ((st_cur == pdhp_pkg::ST_HDR || st_cur == pdhp_pkg::ST_SID || st_cur == pdhp_pkg::ST_SUB) &&
            st_next != pdhp_pkg::ST_DROP) begin
          ev_badhdr = 1'b1; // R19
        end
        st_next = pdhp_pkg::ST_IDLE;
      end
    end
    cnt_next = (st_next != st_cur) ? 2'h0 : cnt_cur + 2'h1;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= pdhp_pkg::ST_IDLE;
      cnt_reg <= 2'h0;
    end else if (byte_in) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sid_reg <= '0;
      idx_reg <= '0;
      mpeg_reg <= 1'b0;
      seqv_reg <= 1'b0;
      seq_hi_reg <= '0;
    end else if (byte_in) begin
      if (st_cur == pdhp_pkg::ST_SID) begin
        sid_reg <= {sid_reg[15:0], IN_DATA};
        idx_reg <= hit_idx;
        mpeg_reg <= hit_cls[0];
      end
      if (st_cur == pdhp_pkg::ST_SUB && cnt_cur == 2'h0) begin
        seqv_reg <= IN_DATA[pdhp_pkg::SUB_S_BIT];
      end
      if (st_cur == pdhp_pkg::ST_SUB && cnt_cur == 2'h2) begin
        seq_hi_reg <= IN_DATA;
      end
    end
  end

  // Segment position inside the payload
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seg_reg <= '0;
    end else if (byte_in) begin
      if (st_cur != pdhp_pkg::ST_PAY) begin
        seg_reg <= '0;
      end else if (!mpeg_reg) begin
        seg_reg <= 8'h01; // R21
      end else begin
        seg_reg <= (seg_reg == pdhp_pkg::MPEG_SEG_LAST) ? 8'h00 : seg_reg + 8'h01; // R20
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OUT_VALID <= 1'b0;
      OUT_DATA <= '0;
      OUT_SOS <= 1'b0;
      OUT_EOS <= 1'b0;
      OUT_EOP <= 1'b0;
      OUT_ERR <= 1'b0;
      OUT_MPEG <= 1'b0;
      OUT_SESS <= '0;
    end else if (CE) begin
      OUT_VALID <= emit;
      OUT_DATA <= IN_DATA;
      OUT_SOS <= emit && seg_reg == 8'h00;
      OUT_EOS <= emit && (IN_EOP || (mpeg_reg && seg_reg == pdhp_pkg::MPEG_SEG_LAST)); // R20 R21
      OUT_EOP <= emit && IN_EOP;
      OUT_ERR <= seg_err;
      OUT_MPEG <= mpeg_reg;
      OUT_SESS <= idx_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Session table and sequence tracking
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < SESSIONS; i++) begin
        sess_id_mem[i] <= '0;
        sess_val_mem[i] <= 1'b0;
        sess_sub_mem[i] <= '0;
      end
    end else if (CE && WR) begin
      if (ADDR == pdhp_pkg::ADDR_SESS_ID) begin
        sess_id_mem[sel_reg] <= WDATA;
      end
      if (wr_cfg && !(WDATA[pdhp_pkg::CFG_VALID_BIT] && !wr_cls[2])) begin // R23
        sess_val_mem[sel_reg] <= WDATA[pdhp_pkg::CFG_VALID_BIT];
        sess_sub_mem[sel_reg] <= WDATA[pdhp_pkg::CFG_SUB_LSB +: 5];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < SESSIONS; i++) begin
        last_seq_mem[i] <= '0;
        seq_seen_mem[i] <= 1'b0;
      end
    end else if (CE) begin
      if (wr_cfg) begin
        seq_seen_mem[sel_reg] <= 1'b0;
      end
      if (byte_in && seq_upd) begin
        last_seq_mem[idx_reg] <= seq_now; // R22
        seq_seen_mem[idx_reg] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, flags and counters
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_en_reg <= pdhp_pkg::CTRL_EN_RST;
      ctrl_udp_reg <= pdhp_pkg::CTRL_UDP_RST;
      sel_reg <= '0;
      avp_kind_reg <= '0;
      avp_val_reg <= '0;
    end else if (CE && WR) begin
      if (ADDR == pdhp_pkg::ADDR_CTRL) begin
        ctrl_en_reg <= WDATA[pdhp_pkg::CTRL_EN_BIT];
        ctrl_udp_reg <= WDATA[pdhp_pkg::CTRL_UDP_BIT];
      end
      if (ADDR == pdhp_pkg::ADDR_SEL) begin
        sel_reg <= WDATA[IW-1:0];
      end
      if (ADDR == pdhp_pkg::ADDR_AVP_SEL) begin
        avp_kind_reg <= WDATA[pdhp_pkg::AVP_KIND_LSB +: 2];
        avp_val_reg <= WDATA[pdhp_pkg::AVP_VAL_LSB +: 16];
      end
    end
  end

  // Sticky flags: a new event wins over a write-one-to-clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_rej_reg <= 1'b0;
      tear_reg <= '0;
      TEARDOWN_REQ <= 1'b0;
    end else if (CE) begin
      cfg_rej_reg <= (cfg_rej_reg && !(WR && ADDR == pdhp_pkg::ADDR_STATUS && WDATA[pdhp_pkg::STATUS_REJ_BIT])) ||
                     (wr_cfg && WDATA[pdhp_pkg::CFG_VALID_BIT] && !wr_cls[2]); // R23
      tear_reg <= (tear_reg & ~((WR && ADDR == pdhp_pkg::ADDR_TEARDOWN) ? WDATA[SESSIONS-1:0] : '0)) |
                  ((byte_in && ev_tear) ? (SESSIONS'(1) << tear_idx) : '0); // R18
      TEARDOWN_REQ <= |tear_reg;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_nosess_reg <= '0;
      cnt_badhdr_reg <= '0;
      cnt_seqloss_reg <= '0;
    end else if (byte_in) begin
      if (ev_nosess) begin
        cnt_nosess_reg <= cnt_nosess_reg + 32'h1; // R24
      end
      if (ev_badhdr) begin
        cnt_badhdr_reg <= cnt_badhdr_reg + 32'h1; // R19
      end
      if (ev_seqloss) begin
        cnt_seqloss_reg <= cnt_seqloss_reg + 32'h1; // R22
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attribute formatter
  always_comb begin
    avp_w0 = {pdhp_pkg::AVP_MBIT, 1'b0, 4'h0, pdhp_pkg::AVP_LEN, AVP_VENDOR}; // R6 R7 R8
    unique case (avp_kind_reg)
      pdhp_pkg::AVP_KIND_SUBTYPE: avp_w1 = {SUBTYPE_AVP_TYPE, 11'h000, sess_sub_mem[sel_reg]}; // R5
      pdhp_pkg::AVP_KIND_LAT: avp_w1 = {pdhp_pkg::AVP_TYPE_LAT_DSCP, avp_val_reg}; // R6
      pdhp_pkg::AVP_KIND_SBFD: avp_w1 = {pdhp_pkg::AVP_TYPE_SBFD_DSCP, avp_val_reg}; // R7
      pdhp_pkg::AVP_KIND_MCAST: avp_w1 = {pdhp_pkg::AVP_TYPE_MCAST_PORT, avp_val_reg}; // R8
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  always_comb begin
    rd_next = '0;
    unique case (ADDR)
      pdhp_pkg::ADDR_CTRL: begin
        rd_next[pdhp_pkg::CTRL_EN_BIT] = ctrl_en_reg;
        rd_next[pdhp_pkg::CTRL_UDP_BIT] = ctrl_udp_reg;
      end
      pdhp_pkg::ADDR_STATUS: begin
        rd_next[pdhp_pkg::STATUS_REJ_BIT] = cfg_rej_reg;
        rd_next[pdhp_pkg::STATUS_BUSY_BIT] = st_reg != pdhp_pkg::ST_IDLE;
      end
      pdhp_pkg::ADDR_SEL: rd_next[IW-1:0] = sel_reg;
      pdhp_pkg::ADDR_SESS_ID: rd_next = sess_id_mem[sel_reg];
      pdhp_pkg::ADDR_SESS_CFG: begin
        rd_next[pdhp_pkg::CFG_VALID_BIT] = sess_val_mem[sel_reg];
        rd_next[pdhp_pkg::CFG_SUB_LSB +: 5] = sess_sub_mem[sel_reg];
      end
      pdhp_pkg::ADDR_TEARDOWN: rd_next[SESSIONS-1:0] = tear_reg;
      pdhp_pkg::ADDR_CNT_NOSESS: rd_next = cnt_nosess_reg;
      pdhp_pkg::ADDR_CNT_BADHDR: rd_next = cnt_badhdr_reg;
      pdhp_pkg::ADDR_CNT_SEQLOSS: rd_next = cnt_seqloss_reg;
      pdhp_pkg::ADDR_AVP_SEL: begin
        rd_next[pdhp_pkg::AVP_KIND_LSB +: 2] = avp_kind_reg;
        rd_next[pdhp_pkg::AVP_VAL_LSB +: 16] = avp_val_reg;
      end
      pdhp_pkg::ADDR_AVP_W0: rd_next = avp_w0;
      pdhp_pkg::ADDR_AVP_W1: rd_next = avp_w1;
      default: rd_next = '0;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= RD ? rd_next : 32'h0;
    end
  end
endmodule : pdhp_top

// ==== verilog/pdhp_pkg.sv ====
package pdhp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SEL = 8'h08;
  localparam logic [7:0] ADDR_SESS_ID = 8'h0c;
  localparam logic [7:0] ADDR_SESS_CFG = 8'h10;
  localparam logic [7:0] ADDR_TEARDOWN = 8'h14;
  localparam logic [7:0] ADDR_CNT_NOSESS = 8'h18;
  localparam logic [7:0] ADDR_CNT_BADHDR = 8'h1c;
  localparam logic [7:0] ADDR_CNT_SEQLOSS = 8'h20;
  localparam logic [7:0] ADDR_AVP_SEL = 8'h24;
  localparam logic [7:0] ADDR_AVP_W0 = 8'h28;
  localparam logic [7:0] ADDR_AVP_W1 = 8'h2c;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_UDP_BIT = 1;
  localparam int STATUS_REJ_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;
  localparam int CFG_VALID_BIT = 0;
  localparam int CFG_SUB_LSB = 1;
  localparam int AVP_KIND_LSB = 0;
  localparam int AVP_VAL_LSB = 16;
  localparam int HDR_T_BIT = 7;
  localparam int SUB_V_BIT = 7;
  localparam int SUB_S_BIT = 6;
  localparam int SUB_H_MSB = 5;
  localparam int SUB_H_LSB = 4;
  // Reset values
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic CTRL_UDP_RST = 1'b0;
  // Sublayer subtype codes
  localparam logic [4:0] SUB_MTS = 5'h01, SUB_PKT_LEGACY = 5'h02, SUB_MCH = 5'h03, SUB_PKT_MC = 5'h04;
  localparam logic [4:0] SUB_US_SCQAM = 5'h06, SUB_US_OFDMA = 5'h07, SUB_BWREQ_SCQ = 5'h08;
  localparam logic [4:0] SUB_BWREQ_OFDMA = 5'h09, SUB_PROBE = 5'h0a, SUB_RNG_SCQ = 5'h0b;
  localparam logic [4:0] SUB_RNG_OFDMA = 5'h0c, SUB_MAP_SCQ = 5'h0d, SUB_MAP_OFDMA = 5'h0e;
  localparam logic [4:0] SUB_SPECMAN = 5'h0f, SUB_PNM = 5'h10, SUB_MTS_RET1 = 5'h12;
  localparam logic [4:0] SUB_MTS_FWD2 = 5'h13, SUB_MTS_RET2 = 5'h14, SUB_NDF = 5'h15;
  localparam logic [4:0] SUB_NDR = 5'h16, SUB_EC = 5'h17, SUB_ZBL = 5'h18;
  // Attribute formatting
  localparam logic AVP_MBIT = 1'b1;
  localparam logic [9:0] AVP_LEN = 10'h008;
  localparam logic [15:0] AVP_TYPE_LAT_DSCP = 16'h0012;
  localparam logic [15:0] AVP_TYPE_SBFD_DSCP = 16'h0013;
  localparam logic [15:0] AVP_TYPE_MCAST_PORT = 16'h0014;
  localparam logic [1:0] AVP_KIND_SUBTYPE = 2'h0, AVP_KIND_LAT = 2'h1, AVP_KIND_SBFD = 2'h2, AVP_KIND_MCAST = 2'h3;
  // Header layout
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam logic [1:0] H_LATENCY = 2'h1;
  localparam logic [7:0] MPEG_SEG_LAST = 8'hbb;
  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_SID, ST_SUB, ST_PAY, ST_DROP} pdhp_state_e;
endpackage : pdhp_pkg

// ==== test/pdhp_top_monitor.sv ====
`timescale 1ns/10ps
module pdhp_top_monitor (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic IN_VALID,
  input wire logic IN_SOP,
  input wire logic IN_EOP,
  input wire logic OUT_VALID,
  input wire logic OUT_SOS,
  input wire logic OUT_EOS,
  input wire logic OUT_EOP,
  input wire logic OUT_ERR,
  input wire logic OUT_MPEG,
  input wire logic TEARDOWN_REQ
);
  // Bytes already seen in the current segment
  logic [7:0] seg_cnt_reg;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seg_cnt_reg <= 8'h00;
    end else if (CE && OUT_VALID) begin
      seg_cnt_reg <= OUT_SOS ? 8'h01 : seg_cnt_reg + 8'h01;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence sop_taken;
    CE && IN_VALID && IN_SOP;
  endsequence
  sequence tail_err;
    OUT_VALID && OUT_ERR;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  rd_idle_zero_a: assert property ($past(CE) && !$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside read answer");
  out_latency_a: assert property (OUT_VALID |-> $past(IN_VALID) && $past(CE))
    else $error("payload byte without input byte");
  sos_valid_a: assert property (OUT_SOS |-> OUT_VALID)
    else $error("segment start without byte");
  eop_ends_seg_a: assert property (OUT_EOP |-> OUT_EOS && $past(IN_EOP))
    else $error("packet end not aligned");
  err_mpeg_a: assert property (OUT_ERR |-> OUT_EOP && OUT_MPEG)
    else $error("error flag outside MPEG tail");
  seg_full_a: assert property (OUT_VALID && OUT_MPEG && OUT_EOS && !OUT_ERR |-> !OUT_SOS && seg_cnt_reg == 8'hbb)
    else $error("MPEG segment not 188 bytes");
  seg_bound_a: assert property (OUT_VALID && OUT_MPEG && !OUT_SOS |-> seg_cnt_reg inside {[8'h01:8'hbb]})
    else $error("MPEG segment overruns");
  hdr_quiet_a: assert property (sop_taken |=> !OUT_VALID [*8])
    else $error("output during header");
  tear_follow_a: assert property (tail_err |-> ##[1:3] TEARDOWN_REQ)
    else $error("no teardown after bad tail");
endmodule : pdhp_top_monitor

// ==== test/pdhp_headend.sv ====
`timescale 1ns/10ps
module pdhp_headend (
  input wire logic CLK,
  output logic IN_VALID,
  output logic [7:0] IN_DATA,
  output logic IN_SOP,
  output logic IN_EOP
);
  initial begin
    IN_VALID = 1'b0;
    IN_DATA = 8'h00;
    IN_SOP = 1'b0;
    IN_EOP = 1'b0;
  end
  task send(input logic [31:0] sid, input logic [7:0] fl, input logic [15:0] sq, input int len,
            input logic udp, input logic t);
    logic [7:0] q[$];
    q = {};
    if (udp) begin
      q.push_back({t, 7'h00});
      q.push_back(8'h03);
      q.push_back(8'h00);
      q.push_back(8'h00);
    end
    for (int i = 3; i >= 0; i--) begin
      q.push_back(sid[8 * i +: 8]);
    end
    q.push_back(fl);
    q.push_back(8'h00);
    q.push_back(sq[15:8]);
    q.push_back(sq[7:0]);
    for (int i = 0; i < len; i++) begin
      q.push_back(i[7:0]);
    end
    foreach (q[i]) begin
      @(posedge CLK);
      IN_VALID <= 1'b1;
      IN_DATA <= q[i];
      IN_SOP <= (i == 0);
      IN_EOP <= (i == q.size() - 1);
    end
    @(posedge CLK);
    IN_VALID <= 1'b0;
    IN_SOP <= 1'b0;
    IN_EOP <= 1'b0;
    // Released line shows inverted data
    IN_DATA <= ~q[q.size() - 1];
  endtask : send
endmodule : pdhp_headend

// ==== test/pdhp_top_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
module pdhp_top_tb;
  localparam logic [15:0] SUBT = 16'h0001;
  localparam logic [15:0] VEND = 16'h5a5a; // Arbitrary vendor value
  logic CLK, RST, CE, WR, RD, IN_VALID, IN_SOP, IN_EOP;
  logic OUT_VALID, OUT_SOS, OUT_EOS, OUT_EOP, OUT_ERR, OUT_MPEG, TEARDOWN_REQ, last_mpeg;
  logic [7:0] ADDR, IN_DATA, OUT_DATA, n_sos, n_eos, n_eop, n_err;
  logic [31:0] WDATA, RDATA;
  logic [2:0] OUT_SESS, last_sess;
  logic [15:0] n_out, pidx;
  logic [48:0] res;
  int fails, total_checks;
  logic [31:0] sids [7] = '{32'h11223344, 32'h55667788, 32'h0a0b0c0d, 32'h0e0f1011, 32'h20212223,
                            32'h30313233, 32'h40414243};
  logic [4:0] codes [7] = '{5'h01, 5'h02, 5'h13, 5'h06, 5'h0d, 5'h03, 5'h04};
  logic mp [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  assign res = {n_out, n_sos, n_eos, n_eop, n_err, last_mpeg};
  pdhp_top #(.SESSIONS(8), .SUBTYPE_AVP_TYPE(SUBT), .AVP_VENDOR(VEND)) DUT (.CLK(CLK), .RST(RST), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
    .IN_SOP(IN_SOP), .IN_EOP(IN_EOP), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_SOS(OUT_SOS),
    .OUT_EOS(OUT_EOS), .OUT_EOP(OUT_EOP), .OUT_ERR(OUT_ERR), .OUT_MPEG(OUT_MPEG), .OUT_SESS(OUT_SESS),
    .TEARDOWN_REQ(TEARDOWN_REQ));
  pdhp_headend HE (.CLK(CLK), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA), .IN_SOP(IN_SOP), .IN_EOP(IN_EOP));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Payload collector
  always @(posedge CLK) begin
    if (OUT_VALID === 1'b1) begin
      `CHK(OUT_DATA, pidx[7:0]);
      n_out = n_out + 16'h0001;
      n_sos = n_sos + OUT_SOS;
      n_eos = n_eos + OUT_EOS;
      n_eop = n_eop + OUT_EOP;
      n_err = n_err + OUT_ERR;
      last_mpeg = OUT_MPEG;
      last_sess = OUT_SESS;
      pidx = OUT_EOP ? 16'h0000 : pidx + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    `CHK(RDATA, e);
  endtask : rdc
  task sess(input logic [31:0] i, input logic [31:0] sid, input logic [4:0] c);
    wr(pdhp_pkg::ADDR_SEL, i);
    wr(pdhp_pkg::ADDR_SESS_ID, sid);
    wr(pdhp_pkg::ADDR_SESS_CFG, {26'h0, c, 1'b1});
  endtask : sess
  task pkt(input logic [31:0] sid, input logic [7:0] fl, input logic [15:0] sq, input int len, input logic udp,
           input logic t);
    {n_out, n_sos, n_eos, n_eop, n_err} = '0;
    HE.send(sid, fl, sq, len, udp, t);
    repeat (3) @(posedge CLK);
  endtask : pkt
  task results;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    static logic [7:0] ra [7] = '{pdhp_pkg::ADDR_CTRL, pdhp_pkg::ADDR_STATUS, pdhp_pkg::ADDR_TEARDOWN,
      pdhp_pkg::ADDR_CNT_NOSESS, pdhp_pkg::ADDR_CNT_BADHDR, pdhp_pkg::ADDR_CNT_SEQLOSS, 8'h30};
    foreach (ra[i]) rdc(ra[i], 32'h0);
  endtask : t_reset
  task t_codes;
    wr(pdhp_pkg::ADDR_SEL, 32'h7);
    for (int c = 0; c < 32; c++) begin
      wr(pdhp_pkg::ADDR_SESS_CFG, {26'h0, c[4:0], 1'b1});
      rdc(pdhp_pkg::ADDR_STATUS, {31'h0, c == 0 || c == 5 || c == 17 || c > 24});
      wr(pdhp_pkg::ADDR_STATUS, 32'h1);
    end
    rdc(pdhp_pkg::ADDR_SESS_CFG, 32'h31);
    wr(pdhp_pkg::ADDR_SESS_CFG, 32'h0);
  endtask : t_codes
  task t_types;
    for (int i = 0; i < 7; i++) begin
      if (i != 3) begin
        pkt(sids[i], 8'h00, 16'h0000, 188, 1'b0, 1'b0);
        `CHK({res, last_sess}, {16'h00bc, 32'h01010100, mp[i], i[2:0]});
      end
    end
  endtask : t_types
  task t_mpeg;
    pkt(sids[0], 8'h00, 16'h0000, 376, 1'b0, 1'b0);
    `CHK(res, {16'h0178, 32'h02020100, 1'b1});
    pkt(sids[0], 8'h00, 16'h0000, 200, 1'b0, 1'b0);
    `CHK(res, {16'h00c8, 32'h02020101, 1'b1});
    rdc(pdhp_pkg::ADDR_TEARDOWN, 32'h1);
    `CHK(TEARDOWN_REQ, 1'b1);
    wr(pdhp_pkg::ADDR_TEARDOWN, 32'h1);
    rdc(pdhp_pkg::ADDR_TEARDOWN, 32'h0);
    `CHK(TEARDOWN_REQ, 1'b0);
  endtask : t_mpeg
  task t_upstream;
    pkt(sids[3], 8'h00, 16'h0000, 20, 1'b0, 1'b0);
    `CHK(n_out, 16'h0000);
    rdc(pdhp_pkg::ADDR_TEARDOWN, 32'h8);
    wr(pdhp_pkg::ADDR_TEARDOWN, 32'h8);
  endtask : t_upstream
  task t_drops;
    static logic [7:0] fl [4] = '{8'h80, 8'h20, 8'h10, 8'h00};
    pkt(32'hdeadbeef, 8'h00, 16'h0000, 20, 1'b0, 1'b0);
    `CHK(n_out, 16'h0000);
    rdc(pdhp_pkg::ADDR_CNT_NOSESS, 32'h1);
    // Last entry is a runt with no payload
    foreach (fl[i]) begin
      pkt(sids[1], fl[i], 16'h0000, (i == 3) ? 0 : 20, 1'b0, 1'b0);
      `CHK(n_out, 16'h0000);
    end
    rdc(pdhp_pkg::ADDR_CNT_BADHDR, 32'h3);
  endtask : t_drops
  task t_seq;
    static logic [15:0] sq [5] = '{16'h0064, 16'h0065, 16'h0067, 16'hffff, 16'h0000};
    sess(6, sids[6], codes[6]);
    foreach (sq[i]) pkt(sids[6], 8'h40, sq[i], 4, 1'b0, 1'b0);
    rdc(pdhp_pkg::ADDR_CNT_SEQLOSS, 32'h2);
  endtask : t_seq
  task t_udp;
    wr(pdhp_pkg::ADDR_CTRL, 32'h3);
    pkt(sids[1], 8'h00, 16'h0000, 10, 1'b1, 1'b1);
    `CHK(n_out, 16'h0000);
    pkt(sids[1], 8'h00, 16'h0000, 10, 1'b1, 1'b0);
    `CHK(res, {16'h000a, 32'h01010100, 1'b0});
    rdc(pdhp_pkg::ADDR_CNT_BADHDR, 32'h4);
    // Parser disabled: whole packet dropped
    wr(pdhp_pkg::ADDR_CTRL, 32'h0);
    pkt(sids[1], 8'h00, 16'h0000, 10, 1'b0, 1'b0);
    `CHK(n_out, 16'h0000);
  endtask : t_udp
  task t_avp;
    wr(pdhp_pkg::ADDR_SEL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(pdhp_pkg::ADDR_AVP_SEL, {16'h002e, 14'h0, k[1:0]});
      rdc(pdhp_pkg::ADDR_AVP_W0, {1'b1, 1'b0, 4'h0, 10'h008, VEND});
      rdc(pdhp_pkg::ADDR_AVP_W1, (k == 0) ? {SUBT, 16'h0001} : {16'h0011 + k[15:0], 16'h002e});
    end
    // Clock enable low: strobe ignored
    @(posedge CLK);
    CE <= 1'b0;
    wr(pdhp_pkg::ADDR_SEL, 32'h5);
    CE <= 1'b1;
    rdc(pdhp_pkg::ADDR_SEL, 32'h0);
  endtask : t_avp
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RST = 1'b1;
    CE = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    pidx = 16'h0000;
    {n_out, n_sos, n_eos, n_eop, n_err} = '0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_codes();
    for (int i = 0; i < 7; i++) sess(i, sids[i], codes[i]);
    wr(pdhp_pkg::ADDR_CTRL, 32'h1);
    t_types();
    t_mpeg();
    t_upstream();
    t_drops();
    t_seq();
    t_udp();
    t_avp();
    results();
  end
  initial begin
    repeat (100000) @(posedge CLK);
    fails++;
    results();
  end
endmodule : pdhp_top_tb
bind pdhp_top pdhp_top_monitor u_mon (.CLK(CLK), .RST(RST), .CE(CE), .RD(RD), .RDATA(RDATA),
  .IN_VALID(IN_VALID), .IN_SOP(IN_SOP), .IN_EOP(IN_EOP), .OUT_VALID(OUT_VALID), .OUT_SOS(OUT_SOS),
  .OUT_EOS(OUT_EOS), .OUT_EOP(OUT_EOP), .OUT_ERR(OUT_ERR), .OUT_MPEG(OUT_MPEG), .TEARDOWN_REQ(TEARDOWN_REQ));
